/* shared/ulmcs_consts.svh */
// Register offsets, field positions, reset values and counts of the line and modem control block
`ifndef ULMCS_CONSTS_SVH
`define ULMCS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ULMCS_OFS_DATA      3'h0
`define ULMCS_OFS_IER       3'h1
`define ULMCS_OFS_ALT_FUNC  3'h2
`define ULMCS_OFS_LINE_CTRL 3'h3
`define ULMCS_OFS_MODEM_CTL 3'h4
`define ULMCS_OFS_LINE_STAT 3'h5
`define ULMCS_OFS_MODEM_STA 3'h6

// ----------------------------------------------------------------
// line_control fields
// ----------------------------------------------------------------
`define ULMCS_LC_PAR_EN     3
`define ULMCS_LC_EVEN       4
`define ULMCS_LC_FORCE      5
`define ULMCS_LC_BREAK      6
`define ULMCS_LC_DIV_ACC    7

// ----------------------------------------------------------------
// modem_control fields
// ----------------------------------------------------------------
`define ULMCS_MC_DTR        0
`define ULMCS_MC_RTS        1
`define ULMCS_MC_AUX1       2
`define ULMCS_MC_AUX2       3
`define ULMCS_MC_LOOP       4
`define ULMCS_MC_XON_ANY    5
`define ULMCS_MC_IR         6
`define ULMCS_MC_PRESC      7

// ----------------------------------------------------------------
// interrupt_enable_reg and alternate_function fields
// ----------------------------------------------------------------
`define ULMCS_IE_THR        1
`define ULMCS_IE_MODEM      3
`define ULMCS_AF_MF_LO      1
`define ULMCS_AF_MF_HI      2
`define ULMCS_MF_AUX2       2'h0
`define ULMCS_MF_BAUD       2'h1
`define ULMCS_MF_RXRDY      2'h2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define ULMCS_RST_REG8      8'h00
`define ULMCS_PRESC_LAST    2'h3
`define ULMCS_FIFO_FULL     5'h10

`endif

/* shared/ulmcs_pkg.sv */
// Types shared by the line and modem control block
package ulmcs_pkg;

	// One receive FIFO slot: character plus its error tags
	typedef struct packed {
		logic       brk;
		logic       frm;
		logic       par;
		logic [7:0] data;
	} ulmcs_rx_entry_s;

	typedef logic [2:0] ulmcs_addr_t;
	typedef logic [3:0] ulmcs_ptr_t;
	typedef logic [4:0] ulmcs_count_t;

endpackage : ulmcs_pkg

/* hw/ulmcs_ctrl.sv */
// Line control, modem control, line status and modem status logic of one serial channel
`timescale 1ns/100ps
`include "ulmcs_consts.svh"
// What this block does
// R1 - Parity odd when select bit 0, even when 1, same for transmit and receive.
// R2 - Forced parity sends and expects mark when select 0, space when select 1.
// R3 - Break bit holds the transmit line at space until software clears it.
// R4 - Divisor-access bit swaps data registers for divisor latches at the same addresses.
// R5 - Active-low DTR and RTS pins are the inverse of their control bits.
// R6 - Multi-function pin shows inverse of aux bit two only when select is 00.
// R7 - Aux one has no pin; in loopback it feeds ring, aux two feeds carrier.
// R8 - Control bit 4 selects internal loopback; zero is normal operation.
// R9 - Xon-any resumes halted transmit on any character; flow characters are not stored.
// R10 - Infrared enable routes the line through encoder and decoder; IR output idles low.
// R11 - Prescaler select feeds the baud generator clock divided by one or four.
// R12 - Data-ready is set while any received character is held.
// R13 - Character arriving on a full FIFO sets overrun and is dropped.
// R14 - Parity and framing flags show the tags of the head character.
// R15 - Break character loaded once; further ones ignored until line returns to mark.
// R16 - Holding-empty sets when the shifter takes the byte, clears on host load.
// R17 - Transmitter-empty only when holding register and shifter are both empty.
// R18 - FIFO error summary set while any stored character carries an error tag.
// R19 - Delta CTS, DSR and CD set on any change; request interrupt when enabled.
// R20 - Delta ring sets only when the ring input goes from low to high.
// R21 - CTS and DSR status read inverted pins, or RTS and DTR bits in loopback.
// R22 - Ring and carrier status read inverted pins, or aux one and two in loopback.
// R23 - Reading modem status removes a pending modem status interrupt.
// R24 - Reading modem status clears all four delta flags.
module ulmcs_ctrl
	import ulmcs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// Register port
	input  wire ulmcs_addr_t addr_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        wr_en_i,
	input  wire logic        rd_en_i,
	output logic      [7:0]  rd_data_o,
	// Transmit datapath side
	input  wire logic        tx_serial_i,
	input  wire logic        tx_busy_i,
	input  wire logic        tx_take_i,
	input  wire logic        tx_halted_i,
	output logic      [7:0]  tx_data_o,
	output logic             tx_valid_o,
	output logic             tx_parity_o,
	output logic             tx_resume_o,
	// Receive datapath side
	input  wire logic        rx_char_valid_i,
	input  wire logic [7:0]  rx_char_data_i,
	input  wire logic        rx_parity_bit_i,
	input  wire logic        rx_stop_ok_i,
	input  wire logic        rx_flow_char_i,
	output logic             rx_serial_o,
	// Format and baud settings to the datapath
	output logic      [2:0]  frame_cfg_o,
	output logic             parity_en_o,
	output logic      [15:0] divisor_o,
	output logic             baud_ref_tick_o,
	// Serial and infrared pins
	input  wire logic        rx_i,
	input  wire logic        ir_rx_i,
	input  wire logic        ir_pulse_i,
	output logic             tx_o,
	output logic             ir_tx_o,
	// Modem pins
	input  wire logic        cts_n_i,
	input  wire logic        dsr_n_i,
	input  wire logic        ri_n_i,
	input  wire logic        cd_n_i,
	output logic             dtr_n_o,
	output logic             rts_n_o,
	output logic             mf_n_o,
	// Interrupt requests
	output logic             thr_irq_o,
	output logic             msr_irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Expected parity bit for a character under a given line_control
	function automatic logic par_bit(input logic [7:0] data, input logic [7:0] lc);
		logic ones_odd;
		ones_odd = ^data;
		if (lc[`ULMCS_LC_FORCE]) begin
			par_bit = ~lc[`ULMCS_LC_EVEN]; // R2
		end else if (lc[`ULMCS_LC_EVEN]) begin
			par_bit = ones_odd; // R1
		end else begin
			par_bit = ~ones_odd; // R1
		end
	endfunction : par_bit

	function automatic ulmcs_ptr_t ptr_inc(input ulmcs_ptr_t p);
		ptr_inc = p + 4'h1;
	endfunction : ptr_inc

	// ----------------------------------------------------------------
	// Registers and decode
	// ----------------------------------------------------------------
	logic [7:0]      line_control_reg;
	logic [7:0]      modem_control_reg;
	logic [7:0]      ier_reg;
	logic [7:0]      alternate_function_reg;
	logic [7:0]      divisor_low_reg;
	logic [7:0]      divisor_high_reg;
	logic [7:0]      tx_holding_reg;
	logic            tx_full_reg;
	logic            overrun_reg;
	logic            brk_hold_reg;
	logic [3:0]      delta_reg;
	logic [3:0]      stat_prev_reg;
	logic [1:0]      presc_cnt_reg;
	logic            tick_reg;
	logic            tx_parity_reg;
	logic            resume_reg;
	logic [7:0]      rd_data_reg;
	ulmcs_rx_entry_s rx_mem [16];
	ulmcs_ptr_t      rx_wr_ptr_reg;
	ulmcs_ptr_t      rx_rd_ptr_reg;
	ulmcs_count_t    rx_count_reg;
	ulmcs_count_t    rx_err_cnt_reg;

	logic            div_acc;
	logic            loop_en;
	logic            ir_en;
	logic            tx_line;
	logic            wr_data_sel;
	logic            wr_div_hi;
	logic            rd_data_sel;
	logic            rd_msr;
	logic            rd_lsr;
	logic [3:0]      stat_now;
	logic [3:0]      delta_set;
	logic            rx_full;
	logic            rx_is_break;
	logic            rx_accept;
	logic            rx_push;
	logic            rx_pop;
	ulmcs_rx_entry_s rx_new;
	ulmcs_rx_entry_s rx_head;
	logic [7:0]      line_status;
	logic [7:0]      modem_status;

	assign div_acc     = line_control_reg[`ULMCS_LC_DIV_ACC];
	assign loop_en     = modem_control_reg[`ULMCS_MC_LOOP]; // R8
	assign ir_en       = modem_control_reg[`ULMCS_MC_IR];
	// Divisor latches shadow the data and enable registers
	assign wr_data_sel = wr_en_i && addr_i == `ULMCS_OFS_DATA && !div_acc; // R4
	assign wr_div_hi   = wr_en_i && addr_i == `ULMCS_OFS_IER && div_acc; // R4
	assign rd_data_sel = rd_en_i && addr_i == `ULMCS_OFS_DATA && !div_acc; // R4
	assign rd_msr      = rd_en_i && addr_i == `ULMCS_OFS_MODEM_STA;
	assign rd_lsr      = rd_en_i && addr_i == `ULMCS_OFS_LINE_STAT;

	// Software-written control registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			line_control_reg       <= `ULMCS_RST_REG8;
			modem_control_reg      <= `ULMCS_RST_REG8;
			ier_reg                <= `ULMCS_RST_REG8;
			alternate_function_reg <= `ULMCS_RST_REG8;
			divisor_low_reg        <= `ULMCS_RST_REG8;
			divisor_high_reg       <= `ULMCS_RST_REG8;
		end else if (wr_en_i) begin
			unique case (addr_i)
				`ULMCS_OFS_DATA:      if (div_acc) divisor_low_reg <= wr_data_i; // R4
				`ULMCS_OFS_IER:       if (wr_div_hi) divisor_high_reg <= wr_data_i;
				                      else ier_reg <= wr_data_i;
				`ULMCS_OFS_ALT_FUNC:  alternate_function_reg <= wr_data_i;
				`ULMCS_OFS_LINE_CTRL: line_control_reg <= wr_data_i;
				`ULMCS_OFS_MODEM_CTL: modem_control_reg <= wr_data_i;
				default:              ;
			endcase
		end
	end

	assign frame_cfg_o = line_control_reg[2:0];
	assign parity_en_o = line_control_reg[`ULMCS_LC_PAR_EN];
	assign divisor_o   = {divisor_high_reg, divisor_low_reg};

	// ----------------------------------------------------------------
	// Transmit side
	// ----------------------------------------------------------------
	// Holding register; a host load in the same cycle as a take keeps it full
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_holding_reg <= `ULMCS_RST_REG8;
			tx_full_reg    <= 1'b0;
			tx_parity_reg  <= 1'b0;
		end else begin
			if (wr_data_sel) begin
				tx_holding_reg <= wr_data_i;
				tx_parity_reg  <= par_bit(wr_data_i, line_control_reg); // R1 R2
				tx_full_reg    <= 1'b1; // R16
			end else if (tx_take_i) begin
				tx_full_reg    <= 1'b0; // R16
			end else if (tx_full_reg) begin
				tx_parity_reg  <= par_bit(tx_holding_reg, line_control_reg); // R1 R2
			end
		end
	end

	assign tx_data_o   = tx_holding_reg;
	assign tx_valid_o  = tx_full_reg;
	assign tx_parity_o = tx_parity_reg;
	assign thr_irq_o   = ier_reg[`ULMCS_IE_THR] && !tx_full_reg; // R16

	// Break forces space ahead of both the pin and the loopback path
	assign tx_line = tx_serial_i && !line_control_reg[`ULMCS_LC_BREAK]; // R3
	// Pin rests at mark while the line is looped back or sent as light
	assign tx_o    = tx_line || loop_en || ir_en; // R8 R10
	// Encoder lights only during the pulse slot of a space bit, so idle is dark
	assign ir_tx_o = ir_en && !loop_en && !tx_line && ir_pulse_i; // R10
	assign rx_serial_o = loop_en ? tx_line : (ir_en ? !ir_rx_i : rx_i); // R8 R10

	// Prescaler for the baud generator reference
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			presc_cnt_reg <= 2'h0;
			tick_reg      <= 1'b0;
		end else begin
			presc_cnt_reg <= presc_cnt_reg + 2'h1;
			tick_reg      <= !modem_control_reg[`ULMCS_MC_PRESC] || presc_cnt_reg == `ULMCS_PRESC_LAST; // R11
		end
	end

	assign baud_ref_tick_o = tick_reg;

	// ----------------------------------------------------------------
	// Receive FIFO with error tags
	// ----------------------------------------------------------------
	assign rx_full     = rx_count_reg == `ULMCS_FIFO_FULL;
	assign rx_is_break = !rx_stop_ok_i && rx_char_data_i == 8'h00 &&
	                     !(parity_en_o && rx_parity_bit_i); // R15
	// Flow characters flagged by the datapath are always consumed, whatever the control bits
	assign rx_accept   = rx_char_valid_i && !rx_flow_char_i && !brk_hold_reg; // R9 R15
	assign rx_push     = rx_accept && !rx_full; // R13
	assign rx_pop      = rd_data_sel && rx_count_reg != 5'h00;
	assign rx_head     = rx_mem[rx_rd_ptr_reg];

	always_comb begin
		rx_new.data = rx_char_data_i;
		rx_new.frm  = !rx_stop_ok_i; // R14
		rx_new.par  = parity_en_o && rx_parity_bit_i != par_bit(rx_char_data_i, line_control_reg); // R1 R2 R14
		rx_new.brk  = rx_is_break; // R15
	end

	// Storage array; only written on push so no reset is needed
	always_ff @(posedge clk_i) begin
		if (rx_push) begin
			rx_mem[rx_wr_ptr_reg] <= rx_new;
		end
	end

	// Pointers, fill level and count of tagged entries
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_wr_ptr_reg  <= 4'h0;
			rx_rd_ptr_reg  <= 4'h0;
			rx_count_reg   <= 5'h00;
			rx_err_cnt_reg <= 5'h00;
		end else begin
			if (rx_push) rx_wr_ptr_reg <= ptr_inc(rx_wr_ptr_reg);
			if (rx_pop) rx_rd_ptr_reg <= ptr_inc(rx_rd_ptr_reg);
			rx_count_reg   <= rx_count_reg + {4'h0, rx_push} - {4'h0, rx_pop}; // R12
			rx_err_cnt_reg <= rx_err_cnt_reg + {4'h0, rx_push && (rx_new.par || rx_new.frm || rx_new.brk)}
			                  - {4'h0, rx_pop && (rx_head.par || rx_head.frm || rx_head.brk)}; // R18
		end
	end

	// Overrun is sticky until the line status is read; a new event wins
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overrun_reg <= 1'b0;
		end else if (rx_accept && rx_full) begin
			overrun_reg <= 1'b1; // R13
		end else if (rd_lsr) begin
			overrun_reg <= 1'b0;
		end
	end

	// One break character per break; rearmed when the line goes back to mark
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			brk_hold_reg <= 1'b0;
		end else if (rx_push && rx_is_break) begin
			brk_hold_reg <= 1'b1; // R15
		end else if (rx_serial_o) begin
			brk_hold_reg <= 1'b0; // R15
		end
	end

	// Xon-any: any received character restarts a halted transmitter
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			resume_reg <= 1'b0;
		end else begin
			resume_reg <= modem_control_reg[`ULMCS_MC_XON_ANY] && rx_char_valid_i && tx_halted_i; // R9
		end
	end

	assign tx_resume_o = resume_reg;

	// ----------------------------------------------------------------
	// Line status
	// ----------------------------------------------------------------
	always_comb begin
		line_status[0] = rx_count_reg != 5'h00; // R12
		line_status[1] = overrun_reg; // R13
		line_status[2] = line_status[0] && rx_head.par; // R14
		line_status[3] = line_status[0] && rx_head.frm; // R14
		line_status[4] = line_status[0] && rx_head.brk; // R15
		line_status[5] = !tx_full_reg; // R16
		line_status[6] = !tx_full_reg && !tx_busy_i; // R17
		line_status[7] = rx_err_cnt_reg != 5'h00; // R18
	end

	// ----------------------------------------------------------------
	// Modem status
	// ----------------------------------------------------------------
	// Order is cts, dsr, ri, cd, matching the delta bits
	always_comb begin
		stat_now[0] = loop_en ? modem_control_reg[`ULMCS_MC_RTS]  : !cts_n_i; // R21
		stat_now[1] = loop_en ? modem_control_reg[`ULMCS_MC_DTR]  : !dsr_n_i; // R21
		stat_now[2] = loop_en ? modem_control_reg[`ULMCS_MC_AUX1] : !ri_n_i; // R7 R22
		stat_now[3] = loop_en ? modem_control_reg[`ULMCS_MC_AUX2] : !cd_n_i; // R7 R22
	end

	// Ring counts only its falling status, which is the pin's rising edge
	assign delta_set = {stat_now[3] ^ stat_prev_reg[3],
	                    stat_prev_reg[2] && !stat_now[2], // R20
	                    stat_now[1:0] ^ stat_prev_reg[1:0]}; // R19

	// Deltas are sticky; a change in the reading cycle survives the clear
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_prev_reg <= 4'h0;
			delta_reg     <= 4'h0;
		end else begin
			stat_prev_reg <= stat_now;
			delta_reg     <= (rd_msr ? 4'h0 : delta_reg) | delta_set; // R19 R20 R24
		end
	end

	assign modem_status = {stat_now, delta_reg};
	assign msr_irq_o    = ier_reg[`ULMCS_IE_MODEM] && delta_reg != 4'h0; // R19 R23

	// ----------------------------------------------------------------
	// Pins and read port
	// ----------------------------------------------------------------
	assign dtr_n_o = !modem_control_reg[`ULMCS_MC_DTR]; // R5
	assign rts_n_o = !modem_control_reg[`ULMCS_MC_RTS]; // R5

	// Multi-function pin; the reserved select parks it inactive high
	always_comb begin
		unique case (alternate_function_reg[`ULMCS_AF_MF_HI:`ULMCS_AF_MF_LO])
			`ULMCS_MF_AUX2:  mf_n_o = !modem_control_reg[`ULMCS_MC_AUX2]; // R6
			`ULMCS_MF_BAUD:  mf_n_o = !tick_reg;
			`ULMCS_MF_RXRDY: mf_n_o = !line_status[0];
			default:         mf_n_o = 1'b1;
		endcase
	end

	// Read data registered, valid the cycle after the strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_reg <= 8'h00;
		end else if (rd_en_i) begin
			unique case (addr_i)
				`ULMCS_OFS_DATA:      rd_data_reg <= div_acc ? divisor_low_reg : rx_head.data; // R4
				`ULMCS_OFS_IER:       rd_data_reg <= div_acc ? divisor_high_reg : ier_reg; // R4
				`ULMCS_OFS_ALT_FUNC:  rd_data_reg <= alternate_function_reg;
				`ULMCS_OFS_LINE_CTRL: rd_data_reg <= line_control_reg;
				`ULMCS_OFS_MODEM_CTL: rd_data_reg <= modem_control_reg;
				`ULMCS_OFS_LINE_STAT: rd_data_reg <= line_status;
				`ULMCS_OFS_MODEM_STA: rd_data_reg <= modem_status;
				default:              rd_data_reg <= 8'h00;
			endcase
		end
	end

	assign rd_data_o = rd_data_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_force_parity;
		@(posedge clk_i) disable iff (!arst_n_i)
		(wr_data_sel && line_control_reg[`ULMCS_LC_FORCE]) |=> tx_parity_o == !$past(line_control_reg[`ULMCS_LC_EVEN]);
	endproperty
	a_force_parity: assert property (p_force_parity) else $error("forced parity bit wrong"); // R2

	property p_break_space;
		@(posedge clk_i) disable iff (!arst_n_i)
		(line_control_reg[`ULMCS_LC_BREAK] && !loop_en && !ir_en) |-> !tx_o;
	endproperty
	a_break_space: assert property (p_break_space) else $error("break not driving space"); // R3

	property p_dtr_write;
		@(posedge clk_i) disable iff (!arst_n_i)
		(wr_en_i && addr_i == `ULMCS_OFS_MODEM_CTL) |=> dtr_n_o == !$past(wr_data_i[`ULMCS_MC_DTR]);
	endproperty
	a_dtr_write: assert property (p_dtr_write) else $error("dtr pin not following control write"); // R5

	property p_presc_four;
		@(posedge clk_i) disable iff (!arst_n_i)
		(baud_ref_tick_o && modem_control_reg[`ULMCS_MC_PRESC] && $past(modem_control_reg[`ULMCS_MC_PRESC]))
		|=> !baud_ref_tick_o;
	endproperty
	a_presc_four: assert property (p_presc_four) else $error("prescaler ticks too often"); // R11

	property p_ready_push;
		@(posedge clk_i) disable iff (!arst_n_i)
		(rx_push && !rx_pop) |=> line_status[0] && rx_count_reg == $past(rx_count_reg) + 5'h01;
	endproperty
	a_ready_push: assert property (p_ready_push) else $error("push did not raise data ready"); // R12

	property p_overrun;
		@(posedge clk_i) disable iff (!arst_n_i)
		(rx_accept && rx_full) |=> overrun_reg && rx_wr_ptr_reg == $past(rx_wr_ptr_reg);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged or fifo written"); // R13

	property p_temt;
		@(posedge clk_i) disable iff (!arst_n_i)
		line_status[6] |-> !tx_valid_o && !tx_busy_i;
	endproperty
	a_temt: assert property (p_temt) else $error("transmitter empty while holding a character"); // R17

	property p_ring_edge;
		@(posedge clk_i) disable iff (!arst_n_i)
		(!loop_en && $past(!loop_en) && $rose(ri_n_i)) |=> delta_reg[2];
	endproperty
	a_ring_edge: assert property (p_ring_edge) else $error("ring end not flagged"); // R20

	property p_msr_clear;
		@(posedge clk_i) disable iff (!arst_n_i)
		(rd_msr && delta_set == 4'h0) |=> delta_reg == 4'h0 && !msr_irq_o;
	endproperty
	a_msr_clear: assert property (p_msr_clear) else $error("modem status read did not clear deltas"); // R23 R24

endmodule : ulmcs_ctrl

/* bench/ulmcs_remote.sv */
// Remote modem model: drives the modem status pins and the receive line
`timescale 1ns/100ps
module ulmcs_remote (
	input  wire logic       clk_i,
	input  wire logic [3:0] want_n_i,
	output logic      [3:0] pins_n_o,
	output logic            rx_o
);
	// Pins move just after an edge, as a real modem driver would
	always_ff @(posedge clk_i) begin
		pins_n_o <= want_n_i;
	end
	// No frames are sent, so the pulled-up line rests at mark
	assign rx_o = 1'b1;
endmodule : ulmcs_remote

/* bench/test_uart_line_modem_ctrl_status.sv */
// Self-checking bench of the line and modem control block
`timescale 1ns/100ps
module test_uart_line_modem_ctrl_status;
	import ulmcs_pkg::*;
	logic        clk_i, arst_n_i, wr_en_i, rd_en_i, tx_serial_i, tx_busy_i, tx_take_i, rx_char_valid_i;
	logic        rx_parity_bit_i, rx_stop_ok_i, rx_i, tx_valid_o, tx_parity_o, tx_o, dtr_n_o, rts_n_o;
	logic        mf_n_o, msr_irq_o, tx_halted_i, rx_flow_char_i, ir_rx_i, ir_pulse_i, tx_resume_o, rx_serial_o;
	logic        baud_ref_tick_o, ir_tx_o, thr_irq_o, parity_en_o;
	logic [2:0]  frame_cfg_o;
	logic [7:0]  wr_data_i, rd_data_o, rx_char_data_i, tx_data_o, d, m, n;
	logic [15:0] divisor_o;
	logic [3:0]  want_n, pins_n;
	ulmcs_addr_t addr_i;
	int          fails, check_count, cyc, seed, i;

	// Every pin is driven by the bench or the remote model and looked at somewhere
	ulmcs_ctrl ulmcs_ctrl_inst (.clk_i, .arst_n_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
		.tx_serial_i, .tx_busy_i, .tx_take_i, .tx_halted_i, .tx_data_o, .tx_valid_o, .tx_parity_o,
		.tx_resume_o, .rx_char_valid_i, .rx_char_data_i, .rx_parity_bit_i, .rx_stop_ok_i,
		.rx_flow_char_i, .rx_serial_o, .frame_cfg_o, .parity_en_o, .divisor_o,
		.baud_ref_tick_o, .rx_i, .ir_rx_i, .ir_pulse_i, .tx_o, .ir_tx_o, .cts_n_i(pins_n[0]),
		.dsr_n_i(pins_n[1]), .ri_n_i(pins_n[2]), .cd_n_i(pins_n[3]), .dtr_n_o, .rts_n_o, .mf_n_o,
		.thr_irq_o, .msr_irq_o);
	ulmcs_remote ulmcs_remote_inst (.clk_i, .want_n_i(want_n), .pins_n_o(pins_n), .rx_o(rx_i));

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle register write; the extra 1 ns lets the edge's updates land
	task automatic wr(input int a, input logic [7:0] v);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		addr_i <= ulmcs_addr_t'(a);
		wr_data_i <= v;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
		#1;
	endtask : wr
	// Read, keep the masked bits and compare
	task automatic rc(input int a, input logic [7:0] k, input logic [7:0] exp);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		addr_i <= ulmcs_addr_t'(a);
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1 chk(rd_data_o & k, exp);
	endtask : rc
	// One completed receive character
	task automatic rxc(input logic [7:0] v, input logic ok);
		@(posedge clk_i);
		rx_char_valid_i <= 1'b1;
		rx_char_data_i <= v;
		rx_stop_ok_i <= ok;
		@(posedge clk_i);
		rx_char_valid_i <= 1'b0;
	endtask : rxc
	// Expected parity: s[0] even select, s[1] force
	function automatic logic par(input logic [7:0] v, input logic [1:0] s);
		return s[1] ? ~s[0] : (s[0] ? ^v : ~^v);
	endfunction : par
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h19c3;
		{arst_n_i, wr_en_i, rd_en_i, tx_take_i, rx_char_valid_i, rx_parity_bit_i, tx_busy_i} = 7'h00;
		{tx_halted_i, rx_flow_char_i, ir_rx_i, ir_pulse_i} = 4'h0;
		{tx_serial_i, rx_stop_ok_i, addr_i, wr_data_i, rx_char_data_i} = 21'h180000;
		want_n = 4'hf;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		rc(3, 8'hff, 8'h00);
		rc(4, 8'hff, 8'h00);
		rc(5, 8'hff, 8'h60);
		rc(6, 8'hf0, 8'h00);
		rc(6, 8'h0f, 8'h00);
		// Random modem control values, loopback kept off
		for (i = 0; i < 8; i++) begin
			m = 8'($random(seed)) & 8'hef;
			wr(4, m);
			chk({dtr_n_o, rts_n_o, mf_n_o}, {~m[0], ~m[1], ~m[3]});
			rc(4, 8'hff, m);
		end
		wr(4, 8'h00);
		// Infrared: pin parked at mark, light only in the pulse slot of a space
		wr(4, 8'h40);
		chk(ir_tx_o, 1'b0);
		@(posedge clk_i);
		{tx_serial_i, ir_pulse_i, ir_rx_i} <= 3'b011;
		#1 chk({tx_o, ir_tx_o, rx_serial_o}, 3'b110);
		@(posedge clk_i);
		{tx_serial_i, ir_pulse_i, ir_rx_i} <= 3'b100;
		// Baud reference ticks over eight cycles, prescaler on then off
		for (i = 0; i < 2; i++) begin
			wr(4, {~i[0], 7'h00});
			n = 8'h00;
			repeat (8) begin
				@(posedge clk_i);
				#1 n += baud_ref_tick_o;
			end
			chk(n, i[0] ? 8'h08 : 8'h02);
		end
		wr(3, 8'h40);
		chk(tx_o, 1'b0);
		wr(3, 8'h00);
		chk(tx_o, 1'b1);
		// Every parity mode on a random byte
		for (i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			wr(3, {2'b00, i[1:0], 4'h8});
			wr(0, d);
			@(posedge clk_i);
			#1 chk(tx_parity_o, par(d, i[1:0]));
			chk(tx_data_o, d);
			chk({parity_en_o, frame_cfg_o}, 8'h08);
		end
		rc(5, 8'h60, 8'h00);
		@(posedge clk_i);
		tx_take_i <= 1'b1;
		tx_busy_i <= 1'b1;
		@(posedge clk_i);
		tx_take_i <= 1'b0;
		rc(5, 8'h60, 8'h20);
		@(posedge clk_i);
		tx_busy_i <= 1'b0;
		rc(5, 8'h60, 8'h60);
		// Divisor latches share the data offsets
		wr(3, 8'h80);
		wr(0, d);
		wr(1, m);
		chk(divisor_o[7:0], d);
		chk(divisor_o[15:8], m);
		rc(0, 8'hff, d);
		wr(3, 8'h00);
		chk(tx_valid_o, 1'b0);
		// Receive status, error tags and overrun on a full FIFO
		rxc(d, 1'b1);
		rc(5, 8'h9f, 8'h01);
		rc(0, 8'hff, d);
		rc(5, 8'h01, 8'h00);
		rxc(8'h55, 1'b0);
		rc(5, 8'h9f, 8'h89);
		rc(0, 8'hff, 8'h55);
		rc(5, 8'h89, 8'h00);
		// Xon-any: a flow character restarts the halted transmitter and is not stored
		wr(4, 8'h20);
		@(posedge clk_i);
		{tx_halted_i, rx_flow_char_i} <= 2'b11;
		rxc(8'h13, 1'b1);
		#1 chk(tx_resume_o, 1'b1);
		rc(5, 8'h01, 8'h00);
		chk(tx_resume_o, 1'b0);
		@(posedge clk_i);
		{tx_halted_i, rx_flow_char_i} <= 2'b00;
		// Break looped back: one tagged character, the next dropped until mark returns
		wr(4, 8'h10);
		wr(3, 8'h48);
		rxc(8'h00, 1'b0);
		rxc(8'h00, 1'b0);
		wr(3, 8'h00);
		rc(5, 8'h9f, 8'h9d);
		rc(0, 8'hff, 8'h00);
		rc(5, 8'h01, 8'h00);
		wr(4, 8'h00);
		m = 8'($random(seed));
		rxc(m, 1'b1);
		for (i = 0; i < 16; i++) rxc(8'($random(seed)), 1'b1);
		rc(5, 8'h03, 8'h03);
		rc(5, 8'h02, 8'h00);
		rc(0, 8'hff, m);
		// Modem deltas and their interrupt
		wr(1, 8'h0a);
		chk(thr_irq_o, 1'b1);
		wr(0, d);
		chk(thr_irq_o, 1'b0);
		want_n <= 4'he;
		repeat (3) @(posedge clk_i);
		#1 chk(msr_irq_o, 1'b1);
		rc(6, 8'hff, 8'h11);
		chk(msr_irq_o, 1'b0);
		want_n <= 4'ha;
		repeat (3) @(posedge clk_i);
		rc(6, 8'hff, 8'h50);
		want_n <= 4'he;
		repeat (3) @(posedge clk_i);
		rc(6, 8'hff, 8'h14);
		// Loopback status comes from the control bits, not the pins
		wr(4, 8'h1f);
		chk(tx_o, 1'b1);
		rc(6, 8'hf0, 8'hf0);
		wr(4, 8'h10);
		rc(6, 8'hf0, 8'h00);
		wr(4, 8'h00);
		rc(7, 8'hff, 8'h00);
		end_sim();
	end
endmodule : test_uart_line_modem_ctrl_status
